// ==== hiorm_consts.svh ====
// Offsets, field positions and reset values of the host I/O register map
`ifndef HIORM_CONSTS_SVH
`define HIORM_CONSTS_SVH
`define HIORM_WIN_BYTES 32
`define HIORM_OFS_SLV_BASE 5'h00
`define HIORM_OFS_SLV_MAP 5'h02
`define HIORM_OFS_MST_PAGE 5'h04
`define HIORM_OFS_MST_MOD 5'h06
`define HIORM_OFS_SIGNAL 5'h08
`define HIORM_OFS_BOARD 5'h0a
`define HIORM_OFS_TMR_SLV 5'h10
`define HIORM_OFS_TMR_MST 5'h12
`define HIORM_OFS_TMR_CTL 5'h14
`define HIORM_OFS_TMR_SETUP 5'h16
`define HIORM_RST_WORD 16'h0000
`define HIORM_RST_BYTE 8'h00
`define HIORM_ONLINE_BIT 0
`define HIORM_IDLE_DATA 16'h0000
`endif

// ==== hiorm_pkg.sv ====
// Types shared by the host I/O register map
package hiorm_pkg;
   // One host I/O bus cycle, sampled on the core clock
   typedef struct packed {
      logic [4:0] offset;
      logic rd;
      logic wr;
      logic word;
      logic [15:0] wdata;
   } hiorm_req_t;

   // Write-only configuration held by the card
   typedef struct packed {
      logic [15:0] slave_window_base;
      logic [15:0] slave_window_mapping;
      logic [15:0] master_address_page;
      logic [15:0] master_modifier_enable;
      logic [15:0] board_options;
      logic [7:0] slave_cycle_time_limit;
      logic [7:0] master_cycle_time_limit;
      logic [7:0] controller_time_limit;
      logic [7:0] timer_setup;
   } hiorm_cfg_t;

   // Access check outcome
   typedef enum logic [1:0] {
      HIORM_ACC_OK = 2'b00,
      HIORM_ACC_NOMAP = 2'b01,
      HIORM_ACC_BADSIZE = 2'b11
   } hiorm_acc_t;
endpackage

// ==== hiorm_regs.sv ====
// Host I/O register decode of the expansion-bus interface card
//
// Notes on behaviour
// RULE_01 - Decode 32 byte locations at switch base
// RULE_02 - Signal register readable only as word
// RULE_03 - Timer registers written only as bytes
// RULE_04 - Byte access: low even, high odd
// RULE_05 - Each register read-only or write-only
// RULE_06 - Fixed offsets for the four groups
// RULE_07 - Write registers hold until overwritten
// RULE_08 - Host hard reset clears marked bits
// RULE_09 - Stay offline until software initializes
// RULE_10 - Host checks all devices before transfers
// RULE_11 - Write one sets, zero clears
`timescale 1ns/1ps
`include "hiorm_consts.svh"

module hiorm_regs
   import hiorm_pkg::*;
(
   // Clock, reset, enable
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic clk_en,
   // Host I/O bus pins (asynchronous to core_clk)
   input wire logic [15:0] io_addr,
   input wire logic io_rd_n,
   input wire logic io_wr_n,
   input wire logic io_word,
   input wire logic [15:0] io_wdata,
   // Base address switches
   input wire logic [15:0] base_sw,
   // Live device state to report
   input wire logic [15:0] bus_signal_capture,
   input wire logic [15:0] board_state,
   // Read data and decode status
   output logic [15:0] io_rdata,
   output logic io_rdata_oe,
   output logic io_sel,
   output logic acc_error,
   // Configuration to the card logic
   output hiorm_cfg_t cfg,
   output logic expansion_online
);

   // -------------------------------------------------------------
   // Input synchronisers
   // -------------------------------------------------------------
   logic [34:0] sync1, sync2, next_sync1, next_sync2;
   logic [15:0] sig_s1, sig_s2, st_s1, st_s2;
   logic [15:0] next_sig_s1, next_sig_s2, next_st_s1, next_st_s2;

   // Pins enter through two flops; the first is read only by the second
   always_comb
   begin
      next_sync1 = {io_addr, io_rd_n, io_wr_n, io_word, io_wdata};
      next_sync2 = sync1;
      next_sig_s1 = bus_signal_capture;
      next_sig_s2 = sig_s1;
      next_st_s1 = board_state;
      next_st_s2 = st_s1;
   end

   always_ff @(posedge core_clk)
   begin
      if (!rstn)
      begin
         sync1 <= {16'h0000, 1'b1, 1'b1, 1'b0, 16'h0000};
         sync2 <= {16'h0000, 1'b1, 1'b1, 1'b0, 16'h0000};
         sig_s1 <= 16'h0000;
         sig_s2 <= 16'h0000;
         st_s1 <= 16'h0000;
         st_s2 <= 16'h0000;
      end
      else if (clk_en)
      begin
         sync1 <= next_sync1;
         sync2 <= next_sync2;
         sig_s1 <= next_sig_s1;
         sig_s2 <= next_sig_s2;
         st_s1 <= next_st_s1;
         st_s2 <= next_st_s2;
      end
   end

   // -------------------------------------------------------------
   // Address decode and access check
   // -------------------------------------------------------------
   logic [15:0] s_addr;
   logic s_rd, s_wr, prev_rd, prev_wr, next_prev_rd, next_prev_wr;
   logic rd_edge, wr_edge, hit;
   logic [15:0] rel;
   hiorm_req_t req;
   hiorm_acc_t acc;

   assign s_addr = sync2[34:19];
   assign s_rd = !sync2[18];
   assign s_wr = !sync2[17];

   // Each strobe acts once, on its leading edge
   always_comb
   begin
      next_prev_rd = s_rd;
      next_prev_wr = s_wr;
   end

   always_ff @(posedge core_clk)
   begin
      if (!rstn)
      begin
         prev_rd <= 1'b0;
         prev_wr <= 1'b0;
      end
      else if (clk_en)
      begin
         prev_rd <= next_prev_rd;
         prev_wr <= next_prev_wr;
      end
   end

   assign rd_edge = s_rd && !prev_rd;
   assign wr_edge = s_wr && !prev_wr;
   assign rel = s_addr - base_sw;
   // RULE_01 window of 32
   assign hit = (s_addr >= base_sw) && (rel < 16'(`HIORM_WIN_BYTES));

   always_comb
   begin
      req.offset = rel[4:0];
      req.rd = rd_edge && hit;
      req.wr = wr_edge && hit;
      req.word = sync2[16];
      req.wdata = sync2[15:0];
   end

   // Size and map check; odd word addresses are refused
   always_comb
   begin
      acc = HIORM_ACC_OK;
      // RULE_06 fixed group offsets
      case ({req.offset[4:1], 1'b0})
         `HIORM_OFS_SLV_BASE, `HIORM_OFS_SLV_MAP,
         `HIORM_OFS_MST_PAGE, `HIORM_OFS_MST_MOD:
            // RULE_05 write only
            if (req.rd)
               acc = HIORM_ACC_NOMAP;
         `HIORM_OFS_SIGNAL:
            // RULE_02 word read only
            if (req.wr)
               acc = HIORM_ACC_NOMAP;
            else if (!req.word)
               acc = HIORM_ACC_BADSIZE;
         `HIORM_OFS_BOARD:
            acc = HIORM_ACC_OK;
         `HIORM_OFS_TMR_SLV, `HIORM_OFS_TMR_MST,
         `HIORM_OFS_TMR_CTL, `HIORM_OFS_TMR_SETUP:
            // RULE_03 byte writes only
            if (req.rd)
               acc = HIORM_ACC_NOMAP;
            else if (req.word || req.offset[0])
               acc = HIORM_ACC_BADSIZE;
         default:
            acc = HIORM_ACC_NOMAP;
      endcase
      if (req.word && req.offset[0])
         acc = HIORM_ACC_BADSIZE;
   end

   // -------------------------------------------------------------
   // Write registers
   // -------------------------------------------------------------
   hiorm_cfg_t next_cfg;
   logic next_online;
   logic wr_ok, lo_en, hi_en;
   logic [15:0] wd;

   assign wr_ok = req.wr && (acc == HIORM_ACC_OK);
   // RULE_04 even low, odd high
   assign lo_en = req.word || !req.offset[0];
   assign hi_en = req.word || req.offset[0];
   assign wd = req.word ? req.wdata
      : {req.wdata[7:0], req.wdata[7:0]};

   // RULE_07 hold unless written
   // RULE_11 data taken as written
   always_comb
   begin
      next_cfg = cfg;
      next_online = expansion_online;
      if (wr_ok)
      begin
         case ({req.offset[4:1], 1'b0})
            `HIORM_OFS_SLV_BASE:
            begin
               if (lo_en) next_cfg.slave_window_base[7:0] = wd[7:0];
               if (hi_en) next_cfg.slave_window_base[15:8] = wd[15:8];
            end
            `HIORM_OFS_SLV_MAP:
            begin
               if (lo_en) next_cfg.slave_window_mapping[7:0] = wd[7:0];
               if (hi_en) next_cfg.slave_window_mapping[15:8] = wd[15:8];
            end
            `HIORM_OFS_MST_PAGE:
            begin
               if (lo_en) next_cfg.master_address_page[7:0] = wd[7:0];
               if (hi_en) next_cfg.master_address_page[15:8] = wd[15:8];
            end
            `HIORM_OFS_MST_MOD:
            begin
               if (lo_en) next_cfg.master_modifier_enable[7:0] = wd[7:0];
               if (hi_en)
                  next_cfg.master_modifier_enable[15:8] = wd[15:8];
            end
            `HIORM_OFS_BOARD:
            begin
               if (lo_en)
               begin
                  next_cfg.board_options[7:0] = wd[7:0];
                  // RULE_09 online follows bit 0 of a software write
                  next_online = wd[`HIORM_ONLINE_BIT];
               end
               if (hi_en) next_cfg.board_options[15:8] = wd[15:8];
            end
            `HIORM_OFS_TMR_SLV:
               next_cfg.slave_cycle_time_limit = wd[7:0];
            `HIORM_OFS_TMR_MST:
               next_cfg.master_cycle_time_limit = wd[7:0];
            `HIORM_OFS_TMR_CTL:
               next_cfg.controller_time_limit = wd[7:0];
            `HIORM_OFS_TMR_SETUP:
               next_cfg.timer_setup = wd[7:0];
            default:
               next_cfg = cfg;
         endcase
      end
   end

   // RULE_08 hard reset clears
   always_ff @(posedge core_clk)
   begin
      if (!rstn)
      begin
         cfg <= '0;
         expansion_online <= 1'b0;
      end
      else if (clk_en)
      begin
         cfg <= next_cfg;
         expansion_online <= next_online;
      end
   end

   // -------------------------------------------------------------
   // Read path
   // -------------------------------------------------------------
   logic [15:0] next_rdata, rword;
   logic next_oe, next_sel, next_err;

   // Read data is held until the next accepted read; the output enable only while the read strobe stays low
   always_comb
   begin
      rword = `HIORM_IDLE_DATA;
      case ({req.offset[4:1], 1'b0})
         `HIORM_OFS_SIGNAL: rword = sig_s2;
         // RULE_05 status on read
         `HIORM_OFS_BOARD: rword = st_s2;
         default: rword = `HIORM_IDLE_DATA;
      endcase
      next_rdata = io_rdata;
      next_oe = io_rdata_oe && s_rd;
      next_sel = hit && (s_rd || s_wr);
      next_err = acc_error;
      if (req.rd || req.wr)
         next_err = (acc != HIORM_ACC_OK);
      if (req.rd && acc == HIORM_ACC_OK)
      begin
         next_oe = 1'b1;
         next_rdata = req.word ? rword
            : (req.offset[0] ? {8'h00, rword[15:8]}
                              : {8'h00, rword[7:0]});
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (!rstn)
      begin
         io_rdata <= 16'h0000;
         io_rdata_oe <= 1'b0;
         io_sel <= 1'b0;
         acc_error <= 1'b0;
      end
      else if (clk_en)
      begin
         io_rdata <= next_rdata;
         io_rdata_oe <= next_oe;
         io_sel <= next_sel;
         acc_error <= next_err;
      end
   end

endmodule // hiorm_regs

// ==== hiorm_regs_props.sv ====
// Concurrent checks on the host I/O register map ports
`timescale 1ns/1ps
module hiorm_regs_props
   import hiorm_pkg::*;
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic rstn,
   // Host pins and switches
   input wire logic [15:0] io_addr,
   input wire logic io_rd_n,
   input wire logic io_wr_n,
   input wire logic io_word,
   input wire logic [15:0] base_sw,
   // Outputs watched
   input wire logic [15:0] io_rdata,
   input wire logic io_rdata_oe,
   input wire logic io_sel,
   input wire logic acc_error,
   input wire hiorm_cfg_t cfg,
   input wire logic expansion_online
);
   // Offset in window; below the base it wraps to a large value
   wire logic [15:0] rel = io_addr - base_sw;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rstn);
   sel_in_window_a:
      assert property ($rose(io_sel) |-> $past(rel, 3) < 16'h0020)
      else $error("select outside window");
   oe_on_read_a:
      assert property ($rose(io_rdata_oe) |-> $past(!io_rd_n, 3))
      else $error("read data without read strobe");
   cfg_hold_a:
      assert property ($changed(cfg) |-> $past(!io_wr_n, 3) && !acc_error)
      else $error("config changed without accepted write");
   reset_clear_a:
      assert property (rstn && $past(!rstn) |->
         cfg == '0 && !expansion_online && !io_sel)
      else $error("state not cleared by reset");
   online_bit_a:
      assert property (expansion_online == cfg.board_options[0])
      else $error("online flag differs from control bit");
   byte_upper_a:
      assert property ($rose(io_rdata_oe) && $past(!io_word, 3) |->
         io_rdata[15:8] == 8'h00)
      else $error("byte read upper lane not zero");
   signal_word_a:
      assert property ($rose(io_sel) && $past(!io_rd_n && rel == 16'h8, 3)
         |-> acc_error == $past(!io_word, 3))
      else $error("signal register size check wrong");
   timer_byte_a:
      assert property ($rose(io_sel) && $past(!io_wr_n && io_word &&
         rel[15:3] == 13'h2, 3) |-> acc_error && $stable(cfg))
      else $error("word write to timer accepted");
   ro_write_a:
      assert property ($rose(io_sel) && $past(!io_wr_n && rel == 16'h8, 3)
         |-> acc_error)
      else $error("write to read-only register accepted");
   wo_read_a:
      assert property ($rose(io_sel) && $past(!io_rd_n && rel < 16'h8, 3)
         |-> acc_error)
      else $error("read of configuration group accepted");
   // Main scenarios
   cov_read: cover property ($rose(io_rdata_oe) && !acc_error);
   cov_write: cover property ($changed(cfg));
   cov_refuse: cover property ($rose(io_sel) ##1 acc_error);
endmodule // hiorm_regs_props
bind hiorm_regs hiorm_regs_props hiorm_regs_props_i (.core_clk, .rstn,
   .io_addr, .io_rd_n, .io_wr_n, .io_word, .base_sw, .io_rdata,
   .io_rdata_oe, .io_sel, .acc_error, .cfg, .expansion_online);

// ==== hiorm_host.sv ====
// Host processor model driving I/O bus cycles
`timescale 1ns/1ps
module hiorm_host
(
   // Clock and switch base
   input wire logic core_clk,
   input wire logic [15:0] base_sw,
   // Host I/O pins
   output logic [15:0] io_addr,
   output logic io_rd_n,
   output logic io_wr_n,
   output logic io_word,
   output logic [15:0] io_wdata
);
   initial
   begin
      io_addr = 16'hffff;
      io_rd_n = 1'b1;
      io_wr_n = 1'b1;
      io_word = 1'b0;
      io_wdata = 16'h0000;
   end
   // One cycle; strobe held well past the two-flop sync
   task automatic cycle(input logic [15:0] rel, input logic rd,
      input logic word, input logic [15:0] wd);
      @(negedge core_clk);
      io_addr = base_sw + rel;
      io_word = word;
      io_wdata = wd;
      @(negedge core_clk);
      io_rd_n = !rd;
      io_wr_n = rd;
      repeat (6) @(negedge core_clk);
      io_rd_n = 1'b1;
      io_wr_n = 1'b1;
      repeat (4) @(negedge core_clk);
      io_addr = ~io_addr; // Released bus shows no stale address
      io_wdata = ~io_wdata;
   endtask
endmodule // hiorm_host

// ==== hiorm_regs_test.sv ====
// Self-checking bench for the host I/O register map
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin \
   num_errors++; $display("ERROR %0t got %0h exp %0h", $time, g, e); end end
module hiorm_regs_test;
   import hiorm_pkg::*;
   typedef struct packed {logic sel; logic rd; logic err; logic [15:0] d;
      hiorm_cfg_t c;} hiorm_note_t;
   logic core_clk, rstn, clk_en, io_rd_n, io_wr_n, io_word, io_rdata_oe;
   logic io_sel, acc_error, expansion_online, last_err;
   logic [15:0] io_addr, io_wdata, bus_signal_capture, board_state, io_rdata;
   logic [15:0] base_sw, last_d;
   hiorm_cfg_t cfg, x;
   hiorm_note_t notes[$];
   hiorm_note_t n;
   int num_errors, num_checks, seed, i, r;
   hiorm_regs hiorm_regs_i (.core_clk, .rstn, .clk_en, .io_addr, .io_rd_n,
      .io_wr_n, .io_word, .io_wdata, .base_sw, .bus_signal_capture,
      .board_state, .io_rdata, .io_rdata_oe, .io_sel, .acc_error, .cfg,
      .expansion_online);
   hiorm_host hiorm_host_i (.core_clk, .base_sw, .io_addr, .io_rd_n,
      .io_wr_n, .io_word, .io_wdata);
   initial
   begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end
   function automatic logic [15:0] put(input logic [15:0] o,
      input logic [4:0] a, input logic w, input logic [15:0] v);
      if (w) return v;
      return a[0] ? {v[7:0], o[7:0]} : {o[15:8], v[7:0]};
   endfunction
   // Expected outcome of one access, noted before it is run
   task automatic access(input logic [15:0] p, input logic rd,
      input logic w, input logic [15:0] v);
      logic [4:0] a;
      logic bad;
      logic [15:0] d;
      logic [15:0] s;
      a = p[4:0];
      // Refused or missed reads leave the last read data in place
      d = last_d;
      s = board_state;
      bad = w && a[0];
      if (p > 16'h001f) bad = last_err;
      else if (rd && a == 5'h08 && w) d = bus_signal_capture;
      else if (rd && a[4:1] == 4'h5 && !bad)
         d = w ? s : (a[0] ? {8'h00, s[15:8]} : {8'h00, s[7:0]});
      else if (rd) bad = 1'b1;
      else if (a[4:3] == 2'b10 && !w && !a[0])
         case (a[2:1])
            2'd0: x.slave_cycle_time_limit = v[7:0];
            2'd1: x.master_cycle_time_limit = v[7:0];
            2'd2: x.controller_time_limit = v[7:0];
            default: x.timer_setup = v[7:0];
         endcase
      else if (a < 5'h08 && !bad)
         case (a[2:1])
            2'd0: x.slave_window_base = put(x.slave_window_base, a, w, v);
            2'd1: x.slave_window_mapping = put(x.slave_window_mapping, a, w, v);
            2'd2: x.master_address_page = put(x.master_address_page, a, w, v);
            default: x.master_modifier_enable =
               put(x.master_modifier_enable, a, w, v);
         endcase
      else if (a[4:1] == 4'h5 && !bad)
         x.board_options = put(x.board_options, a, w, v);
      else bad = 1'b1;
      last_err = bad;
      last_d = d;
      notes.push_back('{p < 16'h0020, rd && p < 16'h0020, bad, d, x});
      hiorm_host_i.cycle(p, rd, w, v);
   endtask
   // Results are judged as each strobe is released
   always @(posedge io_rd_n or posedge io_wr_n)
   begin
      if (notes.size() != 0)
      begin
         n = notes.pop_front();
         if (n.rd) `CHK({acc_error, io_rdata, cfg}, {n.err, n.d, n.c})
         else `CHK({acc_error, cfg}, {n.err, n.c})
         `CHK(expansion_online, n.c.board_options[0])
         `CHK({io_sel, io_rdata_oe}, {n.sel, n.rd && !n.err})
      end
   end
   task automatic wrap_up;
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   initial
   begin
      #60000;
      num_errors++;
      wrap_up();
   end
   initial
   begin
      seed = 27155;
      {rstn, clk_en, last_err, last_d, x} = '0;
      clk_en = 1'b1;
      base_sw = 16'h0300;
      bus_signal_capture = 16'h1234;
      board_state = 16'hbeef;
      repeat (10) @(negedge core_clk);
      rstn = 1'b1;
      access(16'h0008, 1'b1, 1'b1, 16'h0000);
      access(16'h0008, 1'b1, 1'b0, 16'h0000);
      access(16'h0008, 1'b0, 1'b1, 16'hffff);
      access(16'h0010, 1'b0, 1'b0, 16'h00a5);
      access(16'h000a, 1'b0, 1'b1, 16'h8001);
      access(16'h000b, 1'b1, 1'b0, 16'h0000);
      $display("directed done");
      for (i = 0; i < 90; i++)
      begin
         r = $random(seed);
         bus_signal_capture = r[31:16];
         board_state = r[15:0] ^ r[31:16];
         access(16'({r} % 34), r[8], r[9], r[31:16]);
      end
      $display("random done");
      @(negedge core_clk);
      rstn = 1'b0;
      repeat (2) @(negedge core_clk);
      rstn = 1'b1;
      {last_err, last_d, x} = '0;
      access(16'h0040, 1'b1, 1'b1, 16'h0000);
      $display("reset done");
      wrap_up();
   end
endmodule // hiorm_regs_test
